// *** core/test_pin_pkg.sv ***
// Shared constants, types and register map of the test pin sharing block.
package test_pin_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [5:0] OFS_CTRL     = 6'h00;
  localparam logic [5:0] OFS_PROBE    = 6'h04;
  localparam logic [5:0] OFS_LOCK     = 6'h08;
  localparam logic [5:0] OFS_USER_OUT = 6'h0C;
  localparam logic [5:0] OFS_USER_IN  = 6'h10;
  localparam logic [5:0] OFS_STATUS   = 6'h14;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int          CTRL_A_EN_BIT = 0;
  localparam int          CTRL_B_EN_BIT = 1;
  localparam logic [1:0]  CTRL_RST      = 2'h0;
  localparam int          SEL_W         = 8;
  localparam int          USER_OE_LSB   = 8;
  localparam logic [31:0] LOCK_KEY      = 32'h5AFE_C0DE;  // Value is arbitrary.

  // Shared pin indices.
  localparam int NPINS       = 6;
  localparam int PIN_TCK     = 0;
  localparam int PIN_TDI     = 1;
  localparam int PIN_TDO     = 2;
  localparam int PIN_TRST    = 3;
  localparam int PIN_PROBE_A = 4;
  localparam int PIN_PROBE_B = 5;

  // ----------------------------------------------------------------
  // Scan controller
  // ----------------------------------------------------------------
  localparam int          IR_W        = 4;
  localparam logic [3:0]  IR_CAPTURE  = 4'h1;
  localparam logic [3:0]  IR_PROBE    = 4'h1;
  localparam logic [3:0]  IR_CHECKSUM = 4'h2;
  localparam logic [3:0]  IR_BYPASS   = 4'hF;
  localparam int          DR_W        = 16;

  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
  } tap_state_t;

  typedef struct packed {
    logic [NPINS-1:0] oe;
    logic [NPINS-1:0] o;
  } user_io_t;

  typedef struct packed {
    logic [SEL_W-1:0] b;
    logic [SEL_W-1:0] a;
  } probe_sel_t;

endpackage

// *** core/sync2.sv ***
// Two flip-flop level synchroniser.
`timescale 1ns/100ps
module sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule

// *** core/probe_mux.sv ***
// One probe channel: selects an internal node and registers it for the pin.
`timescale 1ns/100ps
module probe_mux #(
  parameter int NODES = 256,
  parameter int SW    = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [NODES-1:0] nodes,
  input  wire logic [SW-1:0]    sel,
  input  wire logic             enable,
  output logic                  q_r
);

  // A select beyond the node count shows zero instead of an unknown.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q_r <= 1'b0;
    end else if (enable && (int'(sel) < NODES)) begin
      q_r <= nodes[sel];
    end else begin
      q_r <= 1'b0;
    end
  end

endmodule

// *** core/test_pin_ctrl.sv ***
// Test pin sharing: scan controller, probe channels, pin muxes and register slave.
`timescale 1ns/100ps

module test_pin_ctrl
  import test_pin_pkg::*;
#(
  parameter bit          FLEXIBLE     = 1'b1,
  parameter bit          RESERVE_TRST = 1'b1,
  parameter int          NODES        = 256,
  parameter logic [15:0] CHECKSUM     = 16'h1234  // Value is arbitrary.
) (
  input  wire logic             core_clk,
  input  wire logic             resetn,
  input  wire logic [5:0]       address,
  input  wire logic             read,
  input  wire logic             write,
  input  wire logic [31:0]      writedata,
  output logic      [31:0]      readdata,
  output logic                  waitrequest,
  input  wire logic             scan_clk,
  input  wire logic             tms_in,
  output logic                  tck_out,
  output logic                  tck_oe,
  input  wire logic             tdi_in,
  output logic                  tdi_out,
  output logic                  tdi_oe,
  input  wire logic             tdo_in,
  output logic                  tdo_out,
  output logic                  tdo_oe,
  input  wire logic             trst_in,
  output logic                  trst_out,
  output logic                  trst_oe,
  input  wire logic             probe_out_a_in,
  output logic                  probe_out_a,
  output logic                  probe_out_a_oe,
  input  wire logic             probe_out_b_in,
  output logic                  probe_out_b,
  output logic                  probe_out_b_oe,
  input  wire logic [NODES-1:0] probe_nodes
);

  // ----------------------------------------------------------------
  // Scan clock domain
  // ----------------------------------------------------------------
  tap_state_t       state_r;
  tap_state_t       state_nxt;
  logic [IR_W-1:0]  ir_r;
  logic [IR_W-1:0]  ir_sh_r;
  logic [DR_W-1:0]  dr_sh_r;
  logic             bypass_r;
  logic             mode_r;
  logic             tdo_r;
  logic [DR_W-1:0]  probe_word_r;
  logic             probe_tgl_r;
  logic             tap_rst_n;
  logic             test_mode;
  logic             chk_active;
  logic             shifting;
  logic             serial_bit;

  // Reserved reset pin initialises the scan circuit asynchronously.
  assign tap_rst_n = resetn & (RESERVE_TRST ? trst_in : 1'b1);

  // Standard state walk; TMS high from any state reaches logic reset in five.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      TLR:     state_nxt = tms_in ? TLR : RTI;
      RTI:     state_nxt = tms_in ? SEL_DR : RTI;
      SEL_DR:  state_nxt = tms_in ? SEL_IR : CAP_DR;
      CAP_DR:  state_nxt = tms_in ? EX1_DR : SH_DR;
      SH_DR:   state_nxt = tms_in ? EX1_DR : SH_DR;
      EX1_DR:  state_nxt = tms_in ? UPD_DR : PA_DR;
      PA_DR:   state_nxt = tms_in ? EX2_DR : PA_DR;
      EX2_DR:  state_nxt = tms_in ? UPD_DR : SH_DR;
      UPD_DR:  state_nxt = tms_in ? SEL_DR : RTI;
      SEL_IR:  state_nxt = tms_in ? TLR : CAP_IR;
      CAP_IR:  state_nxt = tms_in ? EX1_IR : SH_IR;
      SH_IR:   state_nxt = tms_in ? EX1_IR : SH_IR;
      EX1_IR:  state_nxt = tms_in ? UPD_IR : PA_IR;
      PA_IR:   state_nxt = tms_in ? EX2_IR : PA_IR;
      EX2_IR:  state_nxt = tms_in ? UPD_IR : SH_IR;
      UPD_IR:  state_nxt = tms_in ? SEL_DR : RTI;
      default: state_nxt = TLR;
    endcase
  end

  // Controller state advances on the tester's clock only.
  always_ff @(posedge scan_clk or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      state_r <= TLR;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Test-mode flag: set when TMS is seen low, cleared as the controller enters
  // logic reset, so five high clocks are enough to hand the pins back.
  always_ff @(posedge scan_clk or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      mode_r <= 1'b0;
    end else if (!tms_in) begin
      mode_r <= 1'b1;
    end else if (state_nxt == TLR) begin
      mode_r <= 1'b0;
    end
  end

  // Dedicated mode never releases the scan clock, data-in and data-out pins to user logic.
  assign test_mode  = FLEXIBLE ? mode_r : 1'b1;
  assign chk_active = test_mode && (ir_r == IR_CHECKSUM);
  assign shifting   = (state_r == SH_DR) || (state_r == SH_IR);

  // Instruction register path.
  always_ff @(posedge scan_clk or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      ir_sh_r <= IR_CAPTURE;
      ir_r    <= IR_BYPASS;
    end else begin
      case (state_r)
        TLR:     ir_r    <= IR_BYPASS;
        CAP_IR:  ir_sh_r <= IR_CAPTURE;
        SH_IR:   ir_sh_r <= {tdi_in, ir_sh_r[IR_W-1:1]};
        UPD_IR:  ir_r    <= ir_sh_r;
        default: ir_r    <= ir_r;
      endcase
    end
  end

  // Data registers: bypass bit and a shared shifter for probe and checksum.
  always_ff @(posedge scan_clk or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      dr_sh_r  <= '0;
      bypass_r <= 1'b0;
    end else if (state_r == CAP_DR) begin
      bypass_r <= 1'b0;
      case (ir_r)
        IR_PROBE:    dr_sh_r <= probe_word_r;
        IR_CHECKSUM: dr_sh_r <= CHECKSUM;
        default:     dr_sh_r <= '0;
      endcase
    end else if (state_r == SH_DR) begin
      bypass_r <= tdi_in;
      dr_sh_r  <= {tdi_in, dr_sh_r[DR_W-1:1]};
    end
  end

  // Probe select loaded over scan; the toggle hands it to the core clock.
  always_ff @(posedge scan_clk or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      probe_word_r <= '0;
      probe_tgl_r  <= 1'b0;
    end else if ((state_r == UPD_DR) && (ir_r == IR_PROBE)) begin
      probe_word_r <= dr_sh_r;
      probe_tgl_r  <= ~probe_tgl_r;
    end
  end

  // TDO changes on the falling edge so the tester samples it stably.
  always_comb begin
    if (state_r == SH_IR) begin
      serial_bit = ir_sh_r[0];
    end else if (ir_r == IR_BYPASS) begin
      serial_bit = bypass_r;
    end else begin
      serial_bit = dr_sh_r[0];
    end
  end

  always_ff @(negedge scan_clk or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      tdo_r <= 1'b0;
    end else begin
      tdo_r <= serial_bit;
    end
  end

  // ----------------------------------------------------------------
  // Crossing into the core clock domain
  // ----------------------------------------------------------------
  logic [2:0]       scan_flags;
  logic             tgl_sync;
  logic             tgl_seen_r;
  logic [NPINS-1:0] pins_in;
  logic [NPINS-1:0] pins_sync;

  assign pins_in = {probe_out_b_in, probe_out_a_in, trst_in, tdo_in, tdi_in, scan_clk};

  sync2 #(.W(3)) u_flag_sync (
    .clk   (core_clk),
    .rst_n (resetn),
    .d     ({state_r == TLR, chk_active, test_mode}),
    .q     (scan_flags)
  );

  sync2 #(.W(1)) u_tgl_sync (
    .clk   (core_clk),
    .rst_n (resetn),
    .d     (probe_tgl_r),
    .q     (tgl_sync)
  );

  sync2 #(.W(NPINS)) u_pin_sync (
    .clk   (core_clk),
    .rst_n (resetn),
    .d     (pins_in),
    .q     (pins_sync)
  );

  // ----------------------------------------------------------------
  // Register slave
  // ----------------------------------------------------------------
  logic [1:0]  ctrl_r;
  probe_sel_t  sel_r;
  logic        lock_r;
  user_io_t    user_r;
  logic        ack_r;
  logic [31:0] rdata_r;
  logic        wr_go;
  logic        probe_a_act;
  logic        probe_b_act;
  logic        probe_a_q;
  logic        probe_b_q;

  // One wait cycle per access; the answer comes on the second edge.
  assign waitrequest = (read || write) && !ack_r;
  assign wr_go       = write && ack_r;
  assign readdata    = rdata_r;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (read || write) && !ack_r;
    end
  end

  // Software control and probe select; scan updates share the select.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_r     <= CTRL_RST;
      sel_r      <= '0;
      user_r     <= '0;
      tgl_seen_r <= 1'b0;
    end else begin
      tgl_seen_r <= tgl_sync;
      if (wr_go && (address == OFS_CTRL)) begin
        ctrl_r <= writedata[1:0];
      end
      if (wr_go && (address == OFS_USER_OUT)) begin
        user_r.o  <= writedata[NPINS-1:0];
        user_r.oe <= writedata[USER_OE_LSB +: NPINS];
      end
      // A scan update arriving with a bus write wins; it is the later intent.
      if (tgl_sync != tgl_seen_r) begin
        sel_r <= probe_word_r[2*SEL_W-1:0];
      end else if (wr_go && (address == OFS_PROBE)) begin
        sel_r <= writedata[2*SEL_W-1:0];
      end
    end
  end

  // The lock only clears with a device reset; it models the fused option.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      lock_r <= 1'b0;
    end else if (wr_go && (address == OFS_LOCK) && (writedata == LOCK_KEY)) begin
      lock_r <= 1'b1;
    end
  end

  // Read data is registered on the waiting edge and stands at the answer.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_r <= '0;
    end else if (read && !ack_r) begin
      case (address)
        OFS_CTRL:     rdata_r <= {30'h0000_0000, ctrl_r};
        OFS_PROBE:    rdata_r <= {16'h0000, sel_r};
        OFS_LOCK:     rdata_r <= {31'h0000_0000, lock_r};
        OFS_USER_OUT: rdata_r <= {18'h0_0000, user_r.oe, 2'h0, user_r.o};
        OFS_USER_IN:  rdata_r <= {26'h000_0000, pins_sync};
        OFS_STATUS:   rdata_r <= {28'h000_0000, lock_r, scan_flags};
        default:      rdata_r <= '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Probe channels
  // ----------------------------------------------------------------
  assign probe_a_act = ctrl_r[CTRL_A_EN_BIT] && !lock_r;
  assign probe_b_act = ctrl_r[CTRL_B_EN_BIT] && !lock_r;

  probe_mux #(.NODES(NODES), .SW(SEL_W)) u_probe_a (
    .clk    (core_clk),
    .rst_n  (resetn),
    .nodes  (probe_nodes),
    .sel    (sel_r.a),
    .enable (probe_a_act),
    .q_r    (probe_a_q)
  );

  probe_mux #(.NODES(NODES), .SW(SEL_W)) u_probe_b (
    .clk    (core_clk),
    .rst_n  (resetn),
    .nodes  (probe_nodes),
    .sel    (sel_r.b),
    .enable (probe_b_act),
    .q_r    (probe_b_q)
  );

  // ----------------------------------------------------------------
  // Pad multiplexers
  // ----------------------------------------------------------------
  // The scan side drives these selects directly: a synchronised copy would
  // leave the pads fighting the tester for two core cycles.
  assign tck_out = user_r.o[PIN_TCK];
  assign tck_oe  = !test_mode && user_r.oe[PIN_TCK];
  assign tdi_out = user_r.o[PIN_TDI];
  assign tdi_oe  = !test_mode && user_r.oe[PIN_TDI];

  // TDO drives while shifting and throughout a checksum run.
  assign tdo_out = test_mode ? tdo_r : user_r.o[PIN_TDO];
  assign tdo_oe  = test_mode ? (shifting || chk_active)
                             : user_r.oe[PIN_TDO];

  // A reserved reset pin is input only; otherwise it is user I/O.
  assign trst_out = user_r.o[PIN_TRST];
  assign trst_oe  = !RESERVE_TRST && user_r.oe[PIN_TRST];

  // Probe pins stream their node live, or fall back to user I/O.
  assign probe_out_a    = probe_a_act ? probe_a_q : user_r.o[PIN_PROBE_A];
  assign probe_out_a_oe = probe_a_act || user_r.oe[PIN_PROBE_A];
  assign probe_out_b    = probe_b_act ? probe_b_q : user_r.o[PIN_PROBE_B];
  assign probe_out_b_oe = probe_b_act || user_r.oe[PIN_PROBE_B];

endmodule

// *** test/test_pin_checker.sv ***
// Port-level assertions for the test pin sharing block.
`timescale 1ns/100ps
module test_pin_checker
  import test_pin_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        resetn,
  input wire logic [5:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  input wire logic        scan_clk,
  input wire logic        tms_in,
  input wire logic        tck_oe,
  input wire logic        tdi_oe,
  input wire logic        tdo_oe,
  input wire logic        trst_in,
  input wire logic        trst_oe,
  input wire logic        probe_out_a_oe,
  input wire logic        probe_out_b_oe
);
  // ----------------------------------------------------------------
  // Shadow of accepted writes
  // ----------------------------------------------------------------
  logic       locked_r;
  logic [1:0] poe_r;

  // Probe pin enables and the lock, as software last wrote them.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      poe_r    <= 2'h0;
      locked_r <= 1'b0;
    end else if (write && !waitrequest) begin
      if (address == OFS_USER_OUT) begin
        poe_r <= writedata[13:12];
      end
      if (address == OFS_LOCK && writedata == LOCK_KEY) begin
        locked_r <= 1'b1;
      end
    end
  end

  a_one_wait: assert property (@(posedge core_clk) disable iff (!resetn)
    $rose(read || write) |-> waitrequest ##1 !waitrequest)
    else $error("access not answered after one wait cycle");
  a_wait_req: assert property (@(posedge core_clk) disable iff (!resetn)
    waitrequest |-> (read || write))
    else $error("wait raised with no access");
  a_unmapped_zero: assert property (@(posedge core_clk) disable iff (!resetn)
    read && !waitrequest && address > OFS_STATUS |-> readdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_trst_input: assert property (@(posedge core_clk) disable iff (!resetn)
    !trst_oe)
    else $error("reset pin driven while reserved");
  a_trst_reset: assert property (@(posedge core_clk) disable iff (!resetn)
    $fell(trst_in) |=> !tdo_oe)
    else $error("scan reset left data out driving");
  a_tms_enter: assert property (@(posedge scan_clk) disable iff (!resetn || !trst_in)
    !tms_in |=> !tdi_oe && !tck_oe)
    else $error("scan pins still user driven after entry");
  a_tlr_release: assert property (@(posedge scan_clk) disable iff (!resetn)
    tms_in [*5] |=> !tdo_oe)
    else $error("scan pins not released at logic reset");
  a_lock_hold: assert property (@(posedge core_clk) disable iff (!resetn)
    locked_r && $past(locked_r, 2) |-> {probe_out_b_oe, probe_out_a_oe} == poe_r)
    else $error("probe active after lock");
endmodule

// *** test/scan_tester.sv ***
// Scan tester model: drives scan clock, mode select, serial data and reset pins.
`timescale 1ns/100ps
module scan_tester
  import test_pin_pkg::*;
(
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  output logic      trst_n,
  input  wire logic tdo
);
  // Clock rests low between frames; the reset pin sits at its pull-up level.
  initial begin
    tck    = 1'b0;
    tms    = 1'b1;
    tdi    = 1'b0;
    trst_n = 1'b1;
  end

  // One scan clock; data out is taken before the rising edge it belongs to.
  task automatic tick(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #3;
    q   = tdo;
    tck = 1'b1;
    #3;
    tck = 1'b0;
  endtask

  // Walk from idle to a shift state, shift LSB first, update and go idle.
  task automatic scan(input logic to_ir, input int n, input logic [15:0] d,
                      output logic [15:0] q);
    logic b;
    q = 16'h0000;
    tick(1'b1, tdi, b);
    if (to_ir) tick(1'b1, tdi, b);
    tick(1'b0, tdi, b);
    tick(1'b0, tdi, b);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, d[i], b);
      q[i] = b;
    end
    tick(1'b1, tdi, b);
    tick(1'b0, tdi, b);
    tdi = ~tdi;  // Released line shows no stale value.
  endtask

  task automatic ir(input logic [IR_W-1:0] v, output logic [IR_W-1:0] c);
    logic [15:0] q;
    scan(1'b1, IR_W, {12'h000, v}, q);
    c = q[IR_W-1:0];
  endtask

  task automatic dr(input logic [DR_W-1:0] v, output logic [DR_W-1:0] c);
    scan(1'b0, DR_W, v, c);
  endtask

  task automatic hold_high(input int n);
    logic b;
    for (int i = 0; i < n; i++) begin
      tick(1'b1, tdi, b);
    end
  endtask

  // Reset pulse long enough to be seen by the core clock, with no scan clock.
  task automatic trst_pulse();
    trst_n = 1'b0;
    #30;
    trst_n = 1'b1;
  endtask
endmodule

// *** test/test_test_pin_sharing_control.sv ***
// Self-checking bench: bus tasks, scan tester, scenarios and verdict.
`timescale 1ns/100ps
module test_test_pin_sharing_control
  import test_pin_pkg::*;
;
  localparam logic [15:0] CHK = 16'h1234;  // Value is arbitrary.
  logic         core_clk, resetn, read, write, scan_clk, tms_in, trst_in, tst_tdi;
  logic [5:0]   address;
  logic [31:0]  writedata, readdata;
  logic         waitrequest, tck_out, tck_oe, tdi_out, tdi_oe, tdo_out, tdo_oe;
  logic         trst_out, trst_oe, pa, pa_oe, pb, pb_oe;
  logic [255:0] probe_nodes;
  wire logic    tdi_in, tdo_in, pa_in, pb_in;
  int           errors, n_checks, cycles;
  logic [3:0]   q4;
  logic [15:0]  q16;
  logic         b;

  // Pin levels from every party's enable; the tester owns data in otherwise.
  assign tdi_in = tdi_oe ? tdi_out : tst_tdi;
  // An undriven data-out line shows the inverse, so a bit taken while released fails.
  assign tdo_in = tdo_oe ? tdo_out : ~tdo_out;
  assign pa_in  = pa_oe ? pa : 1'b0;
  assign pb_in  = pb_oe ? pb : 1'b0;

  test_pin_ctrl #(.CHECKSUM(CHK)) dut (
    .core_clk(core_clk), .resetn(resetn), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .scan_clk(scan_clk), .tms_in(tms_in),
    .tck_out(tck_out), .tck_oe(tck_oe), .tdi_in(tdi_in), .tdi_out(tdi_out),
    .tdi_oe(tdi_oe), .tdo_in(tdo_in), .tdo_out(tdo_out), .tdo_oe(tdo_oe),
    .trst_in(trst_in), .trst_out(trst_out), .trst_oe(trst_oe),
    .probe_out_a_in(pa_in), .probe_out_a(pa), .probe_out_a_oe(pa_oe),
    .probe_out_b_in(pb_in), .probe_out_b(pb), .probe_out_b_oe(pb_oe),
    .probe_nodes(probe_nodes));

  scan_tester u_tst (.tck(scan_clk), .tms(tms_in), .tdi(tst_tdi), .trst_n(trst_in),
    .tdo(tdo_in));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One bus access held until the slave drops its wait.
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge core_clk);
    address   <= a;
    writedata <= d;
    read      <= !wr;
    write     <= wr;
    do begin
      @(posedge core_clk);
    end while (waitrequest !== 1'b0);
    q = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  // Status flags cross two flops, so let them settle before reading.
  task automatic rd_chk(input string what, input logic [5:0] a, input logic [31:0] exp);
    logic [31:0] q;
    repeat (3) @(posedge core_clk);
    bus(1'b0, a, 32'h0000_0000, q);
    check(what, q, exp);
  endtask

  task automatic pchk(input logic on);
    repeat (3) @(negedge core_clk);
    check("probe a", {pa_oe, pa}, on ? {1'b1, probe_nodes[5]} : 2'b00);
    check("probe b", {pb_oe, pb}, on ? {1'b1, probe_nodes[7]} : 2'b00);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rd_chk("ctrl", OFS_CTRL, 32'h0000_0000);
    rd_chk("status", OFS_STATUS, 32'h0000_0004);
    wr(6'h18, 32'hFFFF_FFFF);
    rd_chk("unmapped", 6'h18, 32'h0000_0000);
    check("tdo oe", tdo_oe, 32'h0000_0000);
  endtask

  task automatic t_user();
    wr(OFS_USER_OUT, 32'h0000_3F2A);
    @(negedge core_clk);
    check("user oe", {pb_oe, pa_oe, trst_oe, tdo_oe, tdi_oe, tck_oe}, 32'h37);
    check("user out", {pb, pa, trst_out, tdo_out, tdi_out, tck_out}, 32'h2A);
    wr(OFS_USER_OUT, 32'h0000_0000);
  endtask

  task automatic t_scan();
    u_tst.tick(1'b0, 1'b0, b);
    rd_chk("entered", OFS_STATUS, 32'h0000_0001);
    u_tst.ir(IR_BYPASS, q4);
    check("ir capture", q4, 32'h0000_0001);
    u_tst.dr(16'hC3A5, q16);
    check("bypass", q16, 32'h0000_874A);
    u_tst.hold_high(2);
    rd_chk("not yet", OFS_STATUS, 32'h0000_0001);
    u_tst.hold_high(1);
    rd_chk("released", OFS_STATUS, 32'h0000_0004);
  endtask

  task automatic t_checksum();
    u_tst.tick(1'b0, 1'b0, b);
    u_tst.ir(IR_CHECKSUM, q4);
    check("tdo drives", tdo_oe, 32'h0000_0001);
    u_tst.dr(16'h0000, q16);
    check("checksum", q16, {16'h0000, CHK});
    rd_chk("sum flag", OFS_STATUS, 32'h0000_0003);
    u_tst.hold_high(4);
    check("tdo back", tdo_oe, 32'h0000_0000);
  endtask

  task automatic t_probe_sel();
    u_tst.tick(1'b0, 1'b0, b);
    u_tst.ir(IR_PROBE, q4);
    u_tst.dr(16'h0705, q16);
    u_tst.hold_high(6);
    rd_chk("probe sel", OFS_PROBE, 32'h0000_0705);
  endtask

  task automatic t_probe();
    probe_nodes <= {8{32'h0F96_A5C3}};
    wr(OFS_CTRL, 32'h0000_0003);
    pchk(1'b1);
    @(posedge core_clk);
    probe_nodes <= ~probe_nodes;
    pchk(1'b1);
    wr(OFS_LOCK, 32'h0000_0000);
    pchk(1'b1);
    wr(OFS_CTRL, 32'h0000_0001);
    @(negedge core_clk);
    check("b user", pb_oe, 32'h0000_0000);
    wr(OFS_LOCK, LOCK_KEY);
    wr(OFS_CTRL, 32'h0000_0003);
    pchk(1'b0);
    rd_chk("locked", OFS_STATUS, 32'h0000_000C);
  endtask

  task automatic t_trst();
    u_tst.tick(1'b0, 1'b0, b);
    rd_chk("in test", OFS_STATUS, 32'h0000_0009);
    u_tst.trst_pulse();
    rd_chk("scan reset", OFS_STATUS, 32'h0000_000C);
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // A hang ends the run well past the couple of hundred cycles it needs.
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 8000) begin
      errors++;
      summarize();
    end
  end

  initial begin
    resetn      = 1'b0;
    read        = 1'b0;
    write       = 1'b0;
    address     = 6'h00;
    writedata   = 32'h0000_0000;
    probe_nodes = '0;
    repeat (12) @(posedge core_clk);
    resetn <= 1'b1;
    t_reset();
    t_user();
    t_scan();
    t_checksum();
    t_probe_sel();
    t_probe();
    t_trst();
    summarize();
  end
endmodule

bind test_pin_ctrl test_pin_checker u_chk (.core_clk(core_clk), .resetn(resetn),
  .address(address), .read(read), .write(write), .writedata(writedata),
  .readdata(readdata), .waitrequest(waitrequest), .scan_clk(scan_clk),
  .tms_in(tms_in), .tck_oe(tck_oe), .tdi_oe(tdi_oe), .tdo_oe(tdo_oe),
  .trst_in(trst_in), .trst_oe(trst_oe), .probe_out_a_oe(probe_out_a_oe),
  .probe_out_b_oe(probe_out_b_oe));
